// File: hdl/system_control.sv
// system control register, mode decode and port function selection
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
module system_control
    import sysctl_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [2:0]  mode_pins,
    input  wire logic        sleep_exec,
    input  wire logic        nmi_pin,
    input  wire logic        ram_sel,
    input  wire logic        ram_wr,
    output logic             enter_sleep,
    output logic             enter_standby,
    output logic [17:0]      standby_wait_states,
    output logic             wait_illegal,
    output logic             user_flag_enable,
    output logic             nmi_request,
    output logic             ram_on,
    output logic             ram_external,
    output logic             ram_read_ff,
    output logic             ram_write_block,
    output logic             bus_8bit,
    output logic [23:0]      addr_pin_en,
    output logic             data_bus_en,
    output logic [2:0]       area_count_log2,
    output logic [1:0]       space_size
);

    // register state
    logic [7:0]  system_control_reg;
    logic [7:0]  bus_release_ctrl;
    logic [7:0]  port1_direction;
    logic [7:0]  port2_direction;
    logic [3:0]  port5_direction;
    op_mode_t    op_mode;
    logic        nmi_prev;
    logic        aw_hold;
    logic        w_hold;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // decode the mode pins into a mode
    function automatic op_mode_t decode_mode(input logic [2:0] pins);
        case (pins)
            3'b001:  decode_mode = mode_1;
            3'b011:  decode_mode = mode_3;
            3'b101:  decode_mode = mode_5;
            3'b110:  decode_mode = mode_6;
            3'b111:  decode_mode = mode_7;
            default: decode_mode = mode_none; // modes 2, 4 unused
        endcase
    endfunction : decode_mode

    // map wait code to states
    function automatic logic [17:0] wait_states(input logic [2:0] code);
        case (code)
            3'b000:  wait_states = wait_0;
            3'b001:  wait_states = wait_1;
            3'b010:  wait_states = wait_2;
            3'b011:  wait_states = wait_3;
            3'b100:  wait_states = wait_4;
            3'b101:  wait_states = wait_5;
            default: wait_states = wait_0;
        endcase
    endfunction : wait_states

    // decode the mode pins on every clock edge, in reset or not; pins held steady in operation
    always_ff @(posedge aclk)
    begin
        op_mode <= decode_mode(mode_pins);
    end

    // axi write channels: address and data accepted in either order
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end
        else if (aw_hold && w_hold)
        begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    logic do_write;
    assign do_write = aw_hold && w_hold;

    // write response, slverr for unmapped offsets
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == sysctl_off || aw_addr == mode_off || aw_addr == portcfg_off
                             || aw_addr == ddr_off || aw_addr == busrel_off) ? 2'b00 : 2'b10;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // system control byte, written whole through lane 0
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            system_control_reg <= sysctl_reset; // ram on set at reset
        end
        else if (do_write && aw_addr == sysctl_off && w_strb[0])
        begin
            system_control_reg <= w_data[7:0]; // only a write or a reset changes standby bit
            system_control_reg[rsvd_bit] <= 1'b1;
        end
    end

    // direction and bus release registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port1_direction  <= 8'h00;
            port2_direction  <= 8'h00;
            port5_direction  <= 4'h0;
            bus_release_ctrl <= busrel_reset;
        end
        else if (do_write)
        begin
            if (aw_addr == ddr_off)
            begin
                if (w_strb[0]) port1_direction <= w_data[7:0];
                if (w_strb[1]) port2_direction <= w_data[15:8];
                if (w_strb[2]) port5_direction <= w_data[19:16];
            end
            if (aw_addr == busrel_off && w_strb[0])
                bus_release_ctrl <= w_data[7:0];
        end
    end

    // read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr[7:0])
                sysctl_off:  s_axi_rdata <= {24'h00_0000, system_control_reg};
                mode_off:    s_axi_rdata <= {29'h0000_0000, op_mode};
                portcfg_off: s_axi_rdata <= {addr_pin_en[23:0], 5'h00, bus_8bit, ram_external, data_bus_en};
                ddr_off:     s_axi_rdata <= {12'h000, port5_direction, port2_direction, port1_direction};
                busrel_off:  s_axi_rdata <= {24'h00_0000, bus_release_ctrl};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // nmi edge detect with programmable edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            nmi_prev    <= 1'b1;
            nmi_request <= 1'b0;
        end
        else
        begin
            nmi_prev    <= nmi_pin;
            nmi_request <= system_control_reg[nmi_bit] ? (nmi_pin && !nmi_prev)
                                                        : (!nmi_pin && nmi_prev);
        end
    end

    // sleep instruction steering and control outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enter_sleep         <= 1'b0;
            enter_standby       <= 1'b0;
            standby_wait_states <= wait_0;
            wait_illegal        <= 1'b0;
            user_flag_enable    <= 1'b1;
            ram_on              <= 1'b1;
        end
        else
        begin
            enter_sleep   <= sleep_exec && !system_control_reg[standby_bit];
            enter_standby <= sleep_exec && system_control_reg[standby_bit];
            standby_wait_states <= wait_states(system_control_reg[wait_lsb +: 3]);
            wait_illegal     <= system_control_reg[wait_lsb + 1 +: 2] == 2'b11;
            user_flag_enable <= system_control_reg[ue_bit];
            ram_on           <= system_control_reg[ram_bit];
        end
    end

    // mode dependent pin and memory functions
    logic expanded;
    logic single_chip;
    assign expanded    = op_mode == mode_1 || op_mode == mode_3 || op_mode == mode_5;
    assign single_chip = op_mode == mode_6 || op_mode == mode_7;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ram_external    <= 1'b0;
            ram_read_ff     <= 1'b0;
            ram_write_block <= 1'b0;
            bus_8bit        <= 1'b0;
            data_bus_en     <= 1'b0;
            addr_pin_en     <= 24'h00_0000;
            area_count_log2 <= 3'd3;
            space_size      <= 2'd0;
        end
        else
        begin
            ram_external    <= expanded && !system_control_reg[ram_bit] && ram_sel;
            ram_read_ff     <= single_chip && !system_control_reg[ram_bit] && ram_sel && !ram_wr;
            ram_write_block <= single_chip && !system_control_reg[ram_bit] && ram_sel && ram_wr;
            bus_8bit        <= expanded;
            data_bus_en     <= expanded;
            area_count_log2 <= 3'd3; // eight areas
            case (op_mode)
                mode_1:
                begin
                    addr_pin_en <= 24'h0F_FFFF;
                    space_size  <= 2'd1;
                end
                mode_3:
                begin
                    addr_pin_en <= {~bus_release_ctrl[7:5], 1'b1, 20'hF_FFFF};
                    space_size  <= 2'd2;
                end
                mode_5:
                begin
                    addr_pin_en <= {4'h0, port5_direction, port2_direction, port1_direction};
                    space_size  <= 2'd1;
                end
                mode_6:
                begin
                    addr_pin_en <= 24'h00_0000;
                    space_size  <= 2'd0; // 64 kbyte
                end
                mode_7:
                begin
                    addr_pin_en <= 24'h00_0000;
                    space_size  <= 2'd1;
                end
                default:
                begin
                    addr_pin_en <= 24'h00_0000;
                    space_size  <= 2'd0;
                end
            endcase
        end
    end

endmodule : system_control

// File: inc/sysctl_pkg.sv
// constants, types and register map for system control and mode select
// Operation
// - standby select bit 7 chooses sleep (0) or software standby (1) on sleep
// - standby select stays 1 after interrupt exit; only a software write of 0 or a reset clears it
// - wait field bits 6..4 selects settling states; 11x codes illegal
// - user flag enable bit 3: 0 mask bit, 1 user bit (reset)
// - nmi edge select bit 2: 0 falling edge (reset), 1 rising edge
// - bit 1 reserved, reads 1, writes ignored
// - ram on bit 0, set at reset, kept through software standby
// - ram disabled in expanded modes sends ram range to external bus
// - mode 1 ports 1, 2, 5 drive address A19..A0
// - every expanded mode starts with 8-bit bus on all areas
// - mode 3 adds A20 always, A23..A21 when bus release bits 7..5 are 0
// - mode 5 port pins become address outputs when direction bit set
// - modes 6 and 7 single chip; 64 kbyte and 1 Mbyte spaces
// - port 3 data bus in expanded modes, all ports general in single chip
// - eight areas; ram and register places differ per address space size
// - mode pins 001,011,101,110,111 select modes 1,3,5,6,7; others unused
// - modes 6 and 7 with ram off read ff and ignore writes
package sysctl_pkg;

    // axi byte offsets of the registers
    localparam logic [7:0] sysctl_off = 8'h00;
    localparam logic [7:0] mode_off   = 8'h04;
    localparam logic [7:0] portcfg_off = 8'h08;
    localparam logic [7:0] ddr_off    = 8'h0C;
    localparam logic [7:0] busrel_off = 8'h10;

    // field positions in the system control byte
    localparam int standby_bit = 7;
    localparam int wait_lsb    = 4;
    localparam int ue_bit      = 3;
    localparam int nmi_bit     = 2;
    localparam int rsvd_bit    = 1;
    localparam int ram_bit     = 0;

    // reset values
    localparam logic [7:0] sysctl_reset = 8'h0B;
    localparam logic [7:0] busrel_reset = 8'hE0;

    // settling wait in states per code
    localparam logic [17:0] wait_0 = 18'd8192;
    localparam logic [17:0] wait_1 = 18'd16384;
    localparam logic [17:0] wait_2 = 18'd32768;
    localparam logic [17:0] wait_3 = 18'd65536;
    localparam logic [17:0] wait_4 = 18'd131072;
    localparam logic [17:0] wait_5 = 18'd1024;

    // least settling time in microseconds and clock rate
    localparam int min_settle_us = 7000;
    localparam int clk_mhz       = 50;
    localparam int min_settle_cycles = min_settle_us * clk_mhz;

    // decoded operating modes
    typedef enum logic [2:0]
    {
        mode_none = 3'b000,
        mode_1    = 3'b001,
        mode_3    = 3'b011,
        mode_5    = 3'b101,
        mode_6    = 3'b110,
        mode_7    = 3'b111
    } op_mode_t;

endpackage : sysctl_pkg

// File: verification/ext_bus_model.sv
// external memory on the expanded bus, counts accesses routed to it
`timescale 1ns/100ps
module ext_bus_model
(
    input  wire logic aclk,
    input  wire logic ram_external,
    input  wire logic data_bus_en,
    output int        hits
);
    // one access taken for each routed cycle while the data bus is live
    initial hits = 0;
    always @(posedge aclk) if (ram_external && data_bus_en) hits <= hits + 1;
endmodule : ext_bus_model

// File: verification/system_control_properties.sv
// assertions on the system control ports
`timescale 1ns/100ps
module system_control_properties
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [2:0]  mode_pins,
    input wire logic        sleep_exec,
    input wire logic        nmi_pin,
    input wire logic        ram_sel,
    input wire logic        ram_wr,
    input wire logic        ram_on,
    input wire logic        enter_sleep,
    input wire logic        enter_standby,
    input wire logic        nmi_request,
    input wire logic        ram_external,
    input wire logic        ram_read_ff,
    input wire logic        ram_write_block,
    input wire logic [23:0] addr_pin_en,
    input wire logic        data_bus_en,
    input wire logic [1:0]  space_size
);
    // one clock domain, reset cancels every attempt
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // registered answers tied to their causes
    property p_sleep; sleep_exec |=> enter_sleep != enter_standby; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep choice");
    property p_nmi; nmi_request |-> $past(nmi_pin) != $past(nmi_pin, 2); endproperty
    a_nmi: assert property (p_nmi) else $error("nmi without edge");
    property p_ext; ram_external |-> $past(ram_sel && !ram_on) && data_bus_en; endproperty
    a_ext: assert property (p_ext) else $error("bad external route");
    property p_ff; ram_read_ff |-> $past(ram_sel && !ram_wr && !ram_on) && !data_bus_en; endproperty
    a_ff: assert property (p_ff) else $error("bad ff read");
    property p_blk; ram_write_block |-> $past(ram_sel && ram_wr && !ram_on) && !data_bus_en; endproperty
    a_blk: assert property (p_blk) else $error("bad write block");
    // port roles follow a steady mode
    property p_single; (mode_pins[2:1] == 2'h3)[*3] |=> addr_pin_en == 24'h00_0000 && !data_bus_en; endproperty
    a_single: assert property (p_single) else $error("single chip pins");
    property p_mode1; (mode_pins == 3'h1)[*3] |=> addr_pin_en == 24'h0F_FFFF && data_bus_en && space_size == 2'h1;
    endproperty
    a_mode1: assert property (p_mode1) else $error("mode one pins");
    property p_mode3; (mode_pins == 3'h3)[*3] |=> addr_pin_en[20:0] == 21'h1F_FFFF && space_size == 2'h2; endproperty
    a_mode3: assert property (p_mode3) else $error("mode three pins");
    c_standby: cover property (enter_standby);
    c_ext: cover property (ram_external);
    c_ff: cover property (ram_read_ff);
endmodule : system_control_properties
bind system_control system_control_properties i_props (.*);

// File: verification/tb.sv
// self-checking bench for system control and mode select
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; $display("MISMATCH %0t %h %h", $time, a, e); end end
module tb
    import sysctl_pkg::*;
;
    logic        aclk, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, sleep_exec = 1'h0, nmi_pin = 1'h1;
    logic        ram_sel = 1'h0, ram_wr = 1'h0;
    logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000, s_axi_araddr = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [2:0]  mode_pins = 3'h7, area_count_log2;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, enter_sleep;
    logic        enter_standby, wait_illegal, user_flag_enable, nmi_request, ram_on, ram_external;
    logic        ram_read_ff, ram_write_block, bus_8bit, data_bus_en;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, space_size;
    logic [17:0] standby_wait_states;
    logic [23:0] addr_pin_en;
    int          errors = 0, comparisons = 0, hits;
    logic [17:0] wt [6] = '{wait_0, wait_1, wait_2, wait_3, wait_4, wait_5};
    logic [2:0]  mc [5] = '{3'h1, 3'h3, 3'h5, 3'h6, 3'h7}; // only legal mode codes, never 2 or 4
    logic [23:0] ea [5] = '{24'h0F_FFFF, 24'h1F_FFFF, 24'h00_0000, 24'h00_0000, 24'h00_0000};
    logic [1:0]  sz [5] = '{2'h1, 2'h2, 2'h1, 2'h0, 2'h1};

    system_control i_dut (.*);
    ext_bus_model i_mem (.aclk, .ram_external, .data_bus_en, .hits);

    // free running 50 MHz clock
    initial
    begin
        aclk = 1'h0;
        forever #10 aclk = ~aclk;
    end

    // axi write, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic ad, wd;
        ad = 1'h0;
        wd = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= {24'h00_0000, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            if (ad) s_axi_awvalid <= 1'h0;
            if (wd) s_axi_wvalid <= 1'h0;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        `CHK(s_axi_bresp, er)
        s_axi_bready <= 1'h0;
        // registered outputs follow the register one edge after the response
        @(posedge aclk);
    endtask : wr

    // axi read with expected data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        @(posedge aclk);
        s_axi_araddr <= {24'h00_0000, a};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, er)
        s_axi_rready <= 1'h0;
    endtask : rd

    // reset with mode pins set while held
    task automatic rst(input logic [2:0] m);
        @(posedge aclk);
        aresetn <= 1'h0;
        mode_pins <= m;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (3) @(posedge aclk);
    endtask : rst

    // one sleep instruction and the chosen power-down
    task automatic sleep_chk(input logic s);
        @(posedge aclk);
        sleep_exec <= 1'h1;
        @(posedge aclk);
        sleep_exec <= 1'h0;
        #1;
        `CHK({enter_sleep, enter_standby}, {!s, s})
    endtask : sleep_chk

    // move the nmi pin and count requests
    task automatic nmi_chk(input logic v, input logic [2:0] e);
        logic [2:0] n;
        n = 3'h0;
        @(posedge aclk);
        nmi_pin <= v;
        repeat (4)
        begin
            @(posedge aclk);
            #1;
            n = n + {2'h0, nmi_request};
        end
        `CHK(n, e)
    endtask : nmi_chk

    // one access in the ram range
    task automatic ram_chk(input logic w, input logic x, input logic f, input logic b);
        @(posedge aclk);
        ram_sel <= 1'h1;
        ram_wr <= w;
        @(posedge aclk);
        ram_sel <= 1'h0;
        #1;
        `CHK({ram_external, ram_read_ff, ram_write_block}, {x, f, b})
    endtask : ram_chk

    // verdict and end of run
    task automatic tally_and_finish;
        if (errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // watchdog against a hang
    initial
    begin
        repeat (60000) @(posedge aclk);
        errors++;
        tally_and_finish;
    end

    // test sequence
    initial
    begin
        logic ex;
        rst(3'h7);
        rd(sysctl_off, 32'h0000_000B);
        `CHK({ram_on, user_flag_enable, standby_wait_states}, {2'h3, wt[0]})
        rd(8'h14, 32'h0000_0000, 2'h2);
        wr(8'h14, 32'h0000_0000, 2'h2);
        wr(sysctl_off, 32'h0000_0000);
        rd(sysctl_off, 32'h0000_0002);
        `CHK({ram_on, user_flag_enable}, 2'h0)
        for (int c = 0; c < 8; c++)
        begin
            wr(sysctl_off, 32'(c) << 4);
            if (c < 6) `CHK(standby_wait_states, wt[c])
            `CHK(wait_illegal, 1'(c > 5))
        end
        wr(sysctl_off, 32'h0000_0040); // longest settling wait chosen by software
        `CHK(standby_wait_states, wt[4])
        wr(sysctl_off, 32'h0000_0000);
        sleep_chk(1'h0);
        wr(sysctl_off, 32'h0000_0080);
        sleep_chk(1'h1);
        rd(sysctl_off, 32'h0000_0082);
        wr(sysctl_off, 32'h0000_0000);
        nmi_chk(1'h0, 3'h1);
        nmi_chk(1'h1, 3'h0);
        wr(sysctl_off, 32'h0000_0004);
        nmi_chk(1'h0, 3'h0);
        nmi_chk(1'h1, 3'h1);
        for (int i = 0; i < 5; i++)
        begin
            ex = !(mc[i][2] && mc[i][1]);
            rst(mc[i]);
            rd(mode_off, {29'h0000_0000, mc[i]});
            `CHK({addr_pin_en, space_size, area_count_log2}, {ea[i], sz[i], 3'h3})
            `CHK({data_bus_en, bus_8bit}, {ex, ex})
            wr(sysctl_off, 32'h0000_0000);
            ram_chk(1'h0, ex, !ex, 1'h0);
            ram_chk(1'h1, ex, 1'h0, !ex);
        end
        `CHK(hits, 6)
        rst(3'h5);
        wr(ddr_off, 32'h000F_FFFF);
        `CHK(addr_pin_en, 24'h0F_FFFF)
        rd(ddr_off, 32'h000F_FFFF);
        rd(portcfg_off, 32'h0FFF_FF05);
        rst(3'h3);
        rd(busrel_off, 32'h0000_00E0);
        wr(busrel_off, 32'h0000_0000);
        `CHK(addr_pin_en, 24'hFF_FFFF)
        tally_and_finish;
    end
endmodule : tb
